// >>> hdl/tmr3_pkg.sv
// Constants shared by the timer three capture and compare register block.
package tmr3_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 8;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [ADDR_W-1:0] CAP_LO_ADDR  = 8'h96;
  localparam logic [ADDR_W-1:0] CAP_HI_ADDR  = 8'h97;
  localparam logic [ADDR_W-1:0] CMPA_LO_ADDR = 8'h98;
  localparam logic [ADDR_W-1:0] CMPA_HI_ADDR = 8'h99;
  localparam logic [ADDR_W-1:0] CTRL_ADDR    = 8'h9a;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [WORD_W-1:0] CAP_RESET   = 16'h0000;
  localparam logic [WORD_W-1:0] CMPA_RESET  = 16'h0000;
  localparam logic [BYTE_W-1:0] TEMP_RESET  = 8'h00;
  localparam logic [BYTE_W-1:0] CTRL_RESET  = 8'h00;
  localparam logic [BYTE_W-1:0] RDATA_IDLE  = 8'h00;
  localparam logic [WORD_W-1:0] FIXED_TOP   = 16'hffff;
  localparam int unsigned       CTRL_TOP_SEL = 0;
  localparam int unsigned       CTRL_PIN_EN  = 1;
  localparam logic [BYTE_W-1:0] CTRL_MASK   = 8'h03;

endpackage

// >>> hdl/tmr3_cmp_unit.sv
// Compare A match detector and waveform pin driver.
`timescale 1ns/1ns
module tmr3_cmp_unit (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Values to compare
  input  wire logic [tmr3_pkg::WORD_W-1:0] counter_i,
  input  wire logic [tmr3_pkg::WORD_W-1:0] compare_i,
  input  wire logic                        pin_en_i,
  // Results
  output logic                             match_o,
  output logic                             pin_o
);

  logic eq_prev_ff;
  logic match_ff;
  logic pin_ff;
  logic eq;

  assign eq = (counter_i == compare_i);

  // ****************************************************************
  // Match detection
  // ****************************************************************
  // A counter that halts on the compare value would otherwise fire on
  // every cycle, so only the first cycle of equality counts.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eq_prev_ff <= 1'b0;
      match_ff   <= 1'b0;
    end else begin
      eq_prev_ff <= eq;
      match_ff   <= eq & ~eq_prev_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_ff <= 1'b0;
    end else if (match_ff && pin_en_i) begin
      pin_ff <= ~pin_ff;
    end
  end

  assign match_o = match_ff;
  assign pin_o   = pin_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_match_on_equal: assert property (
    (eq && !eq_prev_ff) |=> match_o)
    else $error("Compare match pulse missing after equality.");

  chk_pin_toggle: assert property (
    (match_o && pin_en_i) |=> (pin_o != $past(pin_o)))
    else $error("Waveform pin did not toggle on match.");

endmodule

// >>> hdl/tmr3_capture_regs.sv
// Capture value and compare A registers of timer unit three.
//
// Overview of operation
// - Capture value joins the high byte location to the low byte location.
// - A full 16-bit value takes two byte accesses on the 8-bit bus.
// - A capture trigger copies the timer counter value into capture value.
// - Selected modes use the capture value as counter TOP.
// - Capture low byte sits at 0x96 below the high byte, reset zero.
// - Compare A is matched against the counter to drive match and pin.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
module tmr3_capture_regs (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Register port
  input  wire logic [tmr3_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [tmr3_pkg::BYTE_W-1:0] reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [tmr3_pkg::BYTE_W-1:0] reg_rdata_o,
  // Timer side
  input  wire logic [tmr3_pkg::WORD_W-1:0] timer_counter_value_i,
  input  wire logic                        capture_trigger_i,
  // Results
  output logic      [tmr3_pkg::WORD_W-1:0] capture_value_o,
  output logic      [tmr3_pkg::WORD_W-1:0] compare_a_value_o,
  output logic      [tmr3_pkg::WORD_W-1:0] top_value_o,
  output logic                             top_from_capture_o,
  output logic                             compare_a_match_o,
  output logic                             compare_a_waveform_pin_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [tmr3_pkg::WORD_W-1:0] join_bytes(
    input logic [tmr3_pkg::BYTE_W-1:0] hi,
    input logic [tmr3_pkg::BYTE_W-1:0] lo
  );
    join_bytes = {hi, lo};
  endfunction

  function automatic logic [tmr3_pkg::BYTE_W-1:0] high_byte(
    input logic [tmr3_pkg::WORD_W-1:0] w
  );
    high_byte = w[tmr3_pkg::WORD_W-1:tmr3_pkg::BYTE_W];
  endfunction

  function automatic logic [tmr3_pkg::BYTE_W-1:0] low_byte(
    input logic [tmr3_pkg::WORD_W-1:0] w
  );
    low_byte = w[tmr3_pkg::BYTE_W-1:0];
  endfunction

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [tmr3_pkg::WORD_W-1:0] capture_value_ff;
  logic [tmr3_pkg::WORD_W-1:0] compare_a_value_ff;
  logic [tmr3_pkg::BYTE_W-1:0] temp_hi_ff;
  logic [tmr3_pkg::BYTE_W-1:0] ctrl_ff;
  logic [tmr3_pkg::BYTE_W-1:0] rdata_ff;
  logic [tmr3_pkg::BYTE_W-1:0] nxt_rdata;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic wr_cap_lo;
  logic wr_cap_hi;
  logic wr_cmp_lo;
  logic wr_cmp_hi;
  logic wr_ctrl;
  logic rd_cap_lo;
  logic rd_cmp_lo;

  assign wr_cap_lo = reg_wr_i && (reg_addr_i == tmr3_pkg::CAP_LO_ADDR);
  assign wr_cap_hi = reg_wr_i && (reg_addr_i == tmr3_pkg::CAP_HI_ADDR);
  assign wr_cmp_lo = reg_wr_i && (reg_addr_i == tmr3_pkg::CMPA_LO_ADDR);
  assign wr_cmp_hi = reg_wr_i && (reg_addr_i == tmr3_pkg::CMPA_HI_ADDR);
  assign wr_ctrl   = reg_wr_i && (reg_addr_i == tmr3_pkg::CTRL_ADDR);
  assign rd_cap_lo = reg_rd_i && (reg_addr_i == tmr3_pkg::CAP_LO_ADDR);
  assign rd_cmp_lo = reg_rd_i && (reg_addr_i == tmr3_pkg::CMPA_LO_ADDR);

  // ****************************************************************
  // Shared high-byte latch
  // ****************************************************************
  // One latch serves both wide registers, so interleaving a capture
  // access with a compare access corrupts the pending high byte.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_hi_ff <= tmr3_pkg::TEMP_RESET;
    end else if (wr_cap_hi || wr_cmp_hi) begin
      temp_hi_ff <= reg_wdata_i;
    end else if (rd_cap_lo) begin
      temp_hi_ff <= high_byte(capture_value_ff);
    end else if (rd_cmp_lo) begin
      temp_hi_ff <= high_byte(compare_a_value_ff);
    end
  end

  // ****************************************************************
  // Capture value
  // ****************************************************************
  // A hardware capture outranks a software write in the same cycle:
  // the measured event must never be lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_value_ff <= tmr3_pkg::CAP_RESET;
    end else if (capture_trigger_i) begin
      capture_value_ff <= timer_counter_value_i;
    end else if (wr_cap_lo) begin
      capture_value_ff <= join_bytes(temp_hi_ff, reg_wdata_i);
    end
  end

  // ****************************************************************
  // Compare A value
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_a_value_ff <= tmr3_pkg::CMPA_RESET;
    end else if (wr_cmp_lo) begin
      compare_a_value_ff <= join_bytes(temp_hi_ff, reg_wdata_i);
    end
  end

  // ****************************************************************
  // Control
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= tmr3_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= reg_wdata_i & tmr3_pkg::CTRL_MASK;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Reading a high byte returns the latch, which holds the value
  // frozen by the preceding low byte read.
  always_comb begin
    nxt_rdata = tmr3_pkg::RDATA_IDLE;
    if (reg_rd_i) begin
      case (reg_addr_i)
        tmr3_pkg::CAP_LO_ADDR:  nxt_rdata = low_byte(capture_value_ff);
        tmr3_pkg::CAP_HI_ADDR:  nxt_rdata = temp_hi_ff;
        tmr3_pkg::CMPA_LO_ADDR: nxt_rdata = low_byte(compare_a_value_ff);
        tmr3_pkg::CMPA_HI_ADDR: nxt_rdata = temp_hi_ff;
        tmr3_pkg::CTRL_ADDR:    nxt_rdata = ctrl_ff;
        default:                nxt_rdata = tmr3_pkg::RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= tmr3_pkg::RDATA_IDLE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_o        = rdata_ff;
  assign capture_value_o    = capture_value_ff;
  assign compare_a_value_o  = compare_a_value_ff;
  assign top_from_capture_o = ctrl_ff[tmr3_pkg::CTRL_TOP_SEL];
  assign top_value_o        = top_from_capture_o ? capture_value_ff
                                                 : tmr3_pkg::FIXED_TOP;

  tmr3_cmp_unit u_cmp (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .counter_i (timer_counter_value_i),
    .compare_i (compare_a_value_ff),
    .pin_en_i  (ctrl_ff[tmr3_pkg::CTRL_PIN_EN]),
    .match_o   (compare_a_match_o),
    .pin_o     (compare_a_waveform_pin_o)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr_hi;
    reg_wr_i && (reg_addr_i == tmr3_pkg::CAP_HI_ADDR);
  endsequence

  sequence s_wr_lo_clean;
    reg_wr_i && (reg_addr_i == tmr3_pkg::CAP_LO_ADDR) && !capture_trigger_i;
  endsequence

  sequence s_rd_lo;
    reg_rd_i && (reg_addr_i == tmr3_pkg::CAP_LO_ADDR) && !capture_trigger_i;
  endsequence

  sequence s_rd_hi;
    reg_rd_i && (reg_addr_i == tmr3_pkg::CAP_HI_ADDR);
  endsequence

  chk_capture_copy: assert property (
    capture_trigger_i |=> (capture_value_o == $past(timer_counter_value_i)))
    else $error("Capture did not copy the counter value.");

  chk_write_pair: assert property (
    (s_wr_hi ##1 s_wr_lo_clean) |=>
      (capture_value_o == join_bytes($past(reg_wdata_i, 2),
                                     $past(reg_wdata_i))))
    else $error("High then low write did not land as one word.");

  chk_hi_write_alone: assert property (
    (s_wr_hi and !capture_trigger_i) |=> $stable(capture_value_o))
    else $error("High byte write changed the capture value.");

  chk_read_pair: assert property (
    (s_rd_lo ##1 s_rd_hi) |=>
      (reg_rdata_o == high_byte($past(capture_value_o, 2))))
    else $error("High byte read did not match the frozen word.");

  chk_low_read: assert property (
    s_rd_lo |=> (reg_rdata_o == low_byte($past(capture_value_o))))
    else $error("Low byte read at its address returned wrong data.");

  chk_read_idle: assert property (
    !reg_rd_i |=> (reg_rdata_o == tmr3_pkg::RDATA_IDLE))
    else $error("Read data not idle after a cycle with no read.");

  chk_top_select: assert property (
    top_from_capture_o |-> (top_value_o == capture_value_o))
    else $error("TOP does not follow the capture value.");

  chk_reset_zero: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> (capture_value_o == tmr3_pkg::CAP_RESET &&
               compare_a_value_o == tmr3_pkg::CMPA_RESET))
    else $error("Wide registers not zero after reset.");

  sequence s_cmp_wr_hi;
    reg_wr_i && (reg_addr_i == tmr3_pkg::CMPA_HI_ADDR);
  endsequence

  sequence s_cmp_wr_lo;
    reg_wr_i && (reg_addr_i == tmr3_pkg::CMPA_LO_ADDR);
  endsequence

  sequence s_cmp_rd_lo;
    reg_rd_i && (reg_addr_i == tmr3_pkg::CMPA_LO_ADDR);
  endsequence

  sequence s_cmp_rd_hi;
    reg_rd_i && (reg_addr_i == tmr3_pkg::CMPA_HI_ADDR);
  endsequence

  // The compare register shares the latch, so its word transfers are
  // held to the same pairing as those of the capture value.
  chk_cmp_write_pair: assert property (
    (s_cmp_wr_hi ##1 s_cmp_wr_lo) |=>
      (compare_a_value_o == join_bytes($past(reg_wdata_i, 2),
                                       $past(reg_wdata_i))))
    else $error("Compare high then low write did not land as one word.");

  chk_cmp_read_pair: assert property (
    (s_cmp_rd_lo ##1 s_cmp_rd_hi) |=>
      (reg_rdata_o == high_byte($past(compare_a_value_o, 2))))
    else $error("Compare high byte read did not match the frozen word.");

  chk_cap_hold: assert property (
    (!capture_trigger_i && !wr_cap_lo) |=> $stable(capture_value_o))
    else $error("Capture value changed with no trigger and no write.");

  chk_cmp_hold: assert property (
    !wr_cmp_lo |=> $stable(compare_a_value_o))
    else $error("Compare value changed without a low byte write.");

  chk_latch_low_read: assert property (
    s_rd_lo |=> (temp_hi_ff == high_byte($past(capture_value_o))))
    else $error("Low byte read did not freeze the high byte.");

  chk_top_fixed: assert property (
    !top_from_capture_o |-> (top_value_o == tmr3_pkg::FIXED_TOP))
    else $error("Fixed TOP missing while capture is not selected.");

  chk_ctrl_spare: assert property (
    (reg_rd_i && (reg_addr_i == tmr3_pkg::CTRL_ADDR)) |=>
      ((reg_rdata_o & ~tmr3_pkg::CTRL_MASK) == tmr3_pkg::RDATA_IDLE))
    else $error("Spare control bits did not read as zero.");

  chk_unmapped_read: assert property (
    (reg_rd_i && ((reg_addr_i < tmr3_pkg::CAP_LO_ADDR) ||
                  (reg_addr_i > tmr3_pkg::CTRL_ADDR))) |=>
      (reg_rdata_o == tmr3_pkg::RDATA_IDLE))
    else $error("Unmapped read returned data.");

endmodule

// >>> tb/timer3_capture_register_access_test.sv
// Self-checking testbench for the timer three capture register block.
`timescale 1ns/1ns
module timer3_capture_register_access_test;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic [15:0] timer_counter_value_i = 16'h0100;
  logic        capture_trigger_i = 1'b0;
  logic [15:0] capture_value_o;
  logic [15:0] compare_a_value_o;
  logic [15:0] top_value_o;
  logic        top_from_capture_o;
  logic        compare_a_match_o;
  logic        compare_a_waveform_pin_o;
  int          fails = 0;
  int          total_checks = 0;
  logic [7:0]  d;
  logic [7:0]  d2;

  tmr3_capture_regs DUT (
    .clk_i                    (clk_i),
    .rst_i                    (rst_i),
    .reg_addr_i               (reg_addr_i),
    .reg_wdata_i              (reg_wdata_i),
    .reg_wr_i                 (reg_wr_i),
    .reg_rd_i                 (reg_rd_i),
    .reg_rdata_o              (reg_rdata_o),
    .timer_counter_value_i    (timer_counter_value_i),
    .capture_trigger_i        (capture_trigger_i),
    .capture_value_o          (capture_value_o),
    .compare_a_value_o        (compare_a_value_o),
    .top_value_o              (top_value_o),
    .top_from_capture_o       (top_from_capture_o),
    .compare_a_match_o        (compare_a_match_o),
    .compare_a_waveform_pin_o (compare_a_waveform_pin_o)
  );

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Bus and check helpers
  // ****************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
    #1;
  endtask

  // Read data are sampled in the one cycle where they stand.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 v = reg_rdata_o;
  endtask

  // Back to back strobes with no idle cycle between the two bytes.
  task automatic wr_pair(input logic [7:0] ha, input logic [7:0] hv,
                         input logic [7:0] la, input logic [7:0] lv);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= ha;
    reg_wdata_i <= hv;
    @(posedge clk_i);
    reg_addr_i  <= la;
    reg_wdata_i <= lv;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
    #1;
  endtask

  task automatic rd_pair(input logic [7:0] la, input logic [7:0] ha,
                         output logic [7:0] lv, output logic [7:0] hv);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= la;
    @(posedge clk_i);
    reg_addr_i <= ha;
    #1 lv = reg_rdata_o;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 hv = reg_rdata_o;
  endtask

  task automatic capture(input logic [15:0] v);
    @(posedge clk_i);
    timer_counter_value_i <= v;
    capture_trigger_i     <= 1'b1;
    @(posedge clk_i);
    capture_trigger_i     <= 1'b0;
    #1 check(capture_value_o, v, "capture copy");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_values;
    for (int i = 0; i < 6; i++) begin
      rd(8'h96 + 8'(i), d);
      check(16'(d), 16'h0000, "reset read");
    end
    check(top_value_o, 16'hffff, "reset top");
  endtask

  task automatic capture_write_read;
    wr(tmr3_pkg::CAP_HI_ADDR, 8'ha5);
    check(capture_value_o, 16'h0000, "lone high write");
    wr(tmr3_pkg::CAP_LO_ADDR, 8'h3c);
    check(capture_value_o, 16'ha53c, "word write");
    rd(tmr3_pkg::CAP_LO_ADDR, d);
    check(16'(d), 16'h003c, "low read");
    rd(tmr3_pkg::CAP_HI_ADDR, d);
    check(16'(d), 16'h00a5, "high read");
  endtask

  // A capture between the two reads must not tear the word read.
  task automatic read_atomic;
    rd(tmr3_pkg::CAP_LO_ADDR, d);
    check(16'(d), 16'h003c, "atomic low");
    capture(16'h7e81);
    rd(tmr3_pkg::CAP_HI_ADDR, d);
    check(16'(d), 16'h00a5, "latched high");
  endtask

  task automatic atomic_pairs;
    wr_pair(tmr3_pkg::CAP_HI_ADDR, 8'h5a, tmr3_pkg::CAP_LO_ADDR, 8'hc3);
    check(capture_value_o, 16'h5ac3, "pair write");
    rd_pair(tmr3_pkg::CAP_LO_ADDR, tmr3_pkg::CAP_HI_ADDR, d, d2);
    check(16'(d), 16'h00c3, "pair low read");
    check(16'(d2), 16'h005a, "pair high read");
  endtask

  task automatic capture_back_to_back;
    @(posedge clk_i);
    timer_counter_value_i <= 16'h1234;
    capture_trigger_i     <= 1'b1;
    @(posedge clk_i);
    timer_counter_value_i <= 16'hbeef;
    #1 check(capture_value_o, 16'h1234, "first capture");
    @(posedge clk_i);
    capture_trigger_i     <= 1'b0;
    #1 check(capture_value_o, 16'hbeef, "second capture");
    rd(tmr3_pkg::CAP_LO_ADDR, d);
    check(16'(d), 16'h00ef, "captured low");
    rd(tmr3_pkg::CAP_HI_ADDR, d);
    check(16'(d), 16'h00be, "captured high");
  endtask

  task automatic top_select;
    wr(tmr3_pkg::CTRL_ADDR, 8'h01);
    check(16'(top_from_capture_o), 16'h0001, "top select");
    check(top_value_o, 16'hbeef, "top from capture");
    wr(tmr3_pkg::CTRL_ADDR, 8'h00);
    check(top_value_o, 16'hffff, "fixed top");
  endtask

  task automatic compare_match;
    wr_pair(tmr3_pkg::CMPA_HI_ADDR, 8'h02, tmr3_pkg::CMPA_LO_ADDR, 8'h10);
    wr(tmr3_pkg::CTRL_ADDR, 8'h02);
    check(compare_a_value_o, 16'h0210, "compare write");
    @(posedge clk_i);
    timer_counter_value_i <= 16'h0210;
    @(posedge clk_i);
    #1 check(16'(compare_a_match_o), 16'h0001, "match pulse");
    check(16'(compare_a_waveform_pin_o), 16'h0000, "pin before");
    @(posedge clk_i);
    #1 check(16'(compare_a_match_o), 16'h0000, "match one cycle");
    check(16'(compare_a_waveform_pin_o), 16'h0001, "pin toggle");
    rd_pair(tmr3_pkg::CMPA_LO_ADDR, tmr3_pkg::CMPA_HI_ADDR, d, d2);
    check(16'(d), 16'h0010, "compare low read");
    check(16'(d2), 16'h0002, "compare high read");
  endtask

  task automatic unmapped_access;
    wr(8'h9c, 8'hff);
    rd(8'h9c, d);
    check(16'(d), 16'h0000, "unmapped read");
    wr(tmr3_pkg::CTRL_ADDR, 8'hff);
    rd(tmr3_pkg::CTRL_ADDR, d);
    check(16'(d), 16'h0003, "control spare bits");
    check(capture_value_o, 16'hbeef, "capture untouched");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values;
    capture_write_read;
    read_atomic;
    atomic_pairs;
    capture_back_to_back;
    top_select;
    compare_match;
    unmapped_access;
    tally_and_finish;
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    tally_and_finish;
  end

endmodule
